// *** rtl/sdp_pkg.sv ***
// Shared constants and types for the synchronous DRAM command core.
package sdp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WR_NS       = 15;
  localparam int TWR_CALC      = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_INT       = (TWR_CALC < 1) ? 1 : TWR_CALC;
  localparam logic [2:0] TWR_CYC = 3'(TWR_INT);

  // ==========================================================
  // Address and mode field positions, widths and buffer depth
  localparam int AP_BIT    = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WB_BIT = 9;
  localparam int COL_W     = 8;
  localparam int DQ_W      = 16;
  localparam int FIFO_D    = 16;

  // ==========================================================
  // Values after reset, and the full-page burst length code
  localparam logic [1:0] RST_CL = 2'h2;
  localparam logic [2:0] RST_BL = 3'h0;
  localparam logic [2:0] BL_FULL = 3'h7;

  typedef enum logic [2:0] {
    K_NOP, K_ACT, K_RD, K_WR, K_BT, K_PRE, K_REF, K_LMR
  } sdp_kind_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdp_cmd_type;

  typedef struct packed {
    logic [1:0]       bank;
    logic [COL_W-1:0] col;
    logic [1:0]       be;
    logic [DQ_W-1:0]  data;
  } sdp_wr_type;

  typedef struct packed {
    logic [1:0]            cl;
    logic [2:0]            bl;
    logic                  wsingle;
    logic [3:0]            act;
    logic [3:0]            pend;
    logic [3:0][2:0]       twr;
    logic                  bon;
    logic                  bwr;
    logic                  bap;
    logic                  bfull;
    logic [1:0]            bbank;
    logic [COL_W-1:0]      bcol;
    logic [COL_W-1:0]      bmask;
    logic [COL_W-1:0]      bleft;
    logic [2:0]            pv;
    logic [2:0][DQ_W-1:0]  pd;
  } sdp_st_type;

endpackage : sdp_pkg

// *** rtl/sdp_core.sv ***
// Command core of a four-bank synchronous DRAM with write buffer.
`timescale 1ns/1ps

// ==========================================================
// Write buffer
module sdp_fifo #(
  parameter int W = 28,
  parameter int D = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sdp_fptr_type;

  sdp_fptr_type q;
  sdp_fptr_type d;
  logic [W-1:0] mem [D];
  logic         full;
  logic         empty;

  assign empty         = (q.wp == q.rp);
  assign full          = (q.wp[AW-1:0] == q.rp[AW-1:0]) && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid_in && !full) begin
      d.wp = q.wp + 1'b1;
    end
    if (out_ready_in && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (in_valid_in && !full) begin
      mem[q.wp[AW-1:0]] <= in_data_in;
    end
  end
endmodule : sdp_fifo

// ==========================================================
// Device core
// What this block does and what the controller keeps
// [RL1] Read to other bank ends auto-precharge write
// [RL2] Interrupting read data appears CAS latency later
// [RL3] Interrupted bank precharges after write recovery
// [RL4] Last kept word precedes interrupting read
// [RL5] Write to other bank ends auto-precharge write
// [RL6] Write interrupt delays precharge by write recovery
// [RL7] Last kept word precedes interrupting write
// [RL8] Chip select high means no operation
// [RL9] Mode load may precede refresh cycles
// [RL10] Controller keeps minimum row active time
// [RL11] Address bits 8, 9, 11 ignored
// [RL12] Auto precharge closes row after burst
// [RL13] Controller waits precharge before reactivating
// [RL14] Write recovery counted in clock cycles
module sdp_core (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [1:0]  ba_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [1:0]  dqm_in,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe_out,
  output logic             buf_ready_out,
  output logic [3:0]       bank_open_out,
  output logic [3:0]       pre_pending_out
);

  function automatic sdp_pkg::sdp_kind_type decode(
    input sdp_pkg::sdp_cmd_type c
  );
    sdp_pkg::sdp_kind_type k;
    k = sdp_pkg::K_NOP;
    if (!c.cs_n) begin // RL8
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h0:    k = sdp_pkg::K_LMR; // RL9
        3'h1:    k = sdp_pkg::K_REF;
        3'h2:    k = sdp_pkg::K_PRE;
        3'h3:    k = sdp_pkg::K_ACT;
        3'h4:    k = sdp_pkg::K_WR;
        3'h5:    k = sdp_pkg::K_RD;
        3'h6:    k = sdp_pkg::K_BT;
        default: k = sdp_pkg::K_NOP;
      endcase
    end
    return k;
  endfunction : decode

  sdp_pkg::sdp_st_type   q;
  sdp_pkg::sdp_st_type   d;
  sdp_pkg::sdp_cmd_type  cmd;
  sdp_pkg::sdp_kind_type kind;
  sdp_pkg::sdp_wr_type   push_w;
  sdp_pkg::sdp_wr_type   drain_w;
  logic [15:0]           mem [1024];
  logic                  push;
  logic                  fetch;
  logic [1:0]            f_bank;
  logic [7:0]            f_col;
  logic                  drain_v;
  logic                  drain_r;
  logic [3:0]            close_v;
  logic [3:0]            defer_v;
  logic [7:0]            len_m1;
  logic                  stop;
  logic [1:0]            oidx;

  assign cmd  = '{cs_n_in, ras_n_in, cas_n_in, we_n_in};
  assign kind = decode(cmd);

  always_comb begin
    d       = q;
    push    = 1'b0;
    push_w  = '{ba_in, addr_in[7:0], ~dqm_in, dq_in};
    fetch   = 1'b0;
    f_bank  = q.bbank;
    f_col   = q.bcol;
    close_v = 4'h0;
    defer_v = 4'h0;
    len_m1  = 8'h00;
    stop    = (kind == sdp_pkg::K_RD) || (kind == sdp_pkg::K_WR) ||
              (kind == sdp_pkg::K_BT) || (kind == sdp_pkg::K_PRE);
    d.pv    = {q.pv[1:0], 1'b0};
    d.pd    = {q.pd[1:0], 16'h0000};
    for (int i = 0; i < 4; i++) begin
      if (q.pend[i]) begin
        d.twr[i] = q.twr[i] - 3'h1;
        if (q.twr[i] <= 3'h1) begin
          d.pend[i] = 1'b0;
          d.act[i]  = 1'b0;
        end
      end
    end
    if (q.bon) begin
      if (stop) begin
        // The old burst ends here; this cycle's data is not its own.
        d.bon = 1'b0; // RL1 RL5 RL4 RL7
        if (q.bap) begin
          if (q.bwr) begin
            defer_v[q.bbank] = 1'b1; // RL3 RL6
          end else begin
            close_v[q.bbank] = 1'b1;
          end
        end
      end else begin
        if (q.bwr) begin
          push   = 1'b1;
          push_w = '{q.bbank, q.bcol, ~dqm_in, dq_in};
        end else begin
          fetch = 1'b1;
        end
        d.bcol = (q.bcol & ~q.bmask) | ((q.bcol + 8'h01) & q.bmask);
        if (!q.bfull) begin
          d.bleft = q.bleft - 8'h01;
          if (q.bleft == 8'h01) begin
            d.bon = 1'b0;
            if (q.bap && q.bwr) begin
              defer_v[q.bbank] = 1'b1; // RL12
            end else if (q.bap) begin
              close_v[q.bbank] = 1'b1; // RL12
            end
          end
        end
      end
    end
    case (kind)
      sdp_pkg::K_ACT: begin
        d.act[ba_in] = 1'b1;
      end
      sdp_pkg::K_PRE: begin
        if (addr_in[sdp_pkg::AP_BIT]) begin
          d.act  = 4'h0;
          d.pend = 4'h0;
        end else begin
          d.act[ba_in]  = 1'b0;
          d.pend[ba_in] = 1'b0;
        end
      end
      sdp_pkg::K_LMR: begin
        d.bl      = addr_in[sdp_pkg::MR_BL_LSB +: 3];
        d.cl      = addr_in[sdp_pkg::MR_CL_LSB +: 2];
        d.wsingle = addr_in[sdp_pkg::MR_WB_BIT];
      end
      sdp_pkg::K_RD, sdp_pkg::K_WR: begin
        // Only the low column bits steer the access.
        d.bbank = ba_in;
        d.bwr   = (kind == sdp_pkg::K_WR);
        d.bap   = addr_in[sdp_pkg::AP_BIT];
        d.bfull = (q.bl == sdp_pkg::BL_FULL) &&
                  !(d.bwr && q.wsingle);
        if (d.bfull) begin
          len_m1 = 8'hFF;
        end else if (d.bwr && q.wsingle) begin
          len_m1 = 8'h00;
        end else begin
          len_m1 = (8'h01 << q.bl[1:0]) - 8'h01;
        end
        d.bmask = len_m1;
        d.bleft = len_m1;
        d.bcol  = (addr_in[7:0] & ~len_m1) |
                  ((addr_in[7:0] + 8'h01) & len_m1); // RL11
        d.bon   = d.bfull || (len_m1 != 8'h00);
        if (d.bwr) begin
          push = 1'b1; // RL7
          d.pv = 3'h0;
        end else begin
          fetch  = 1'b1; // RL2
          f_bank = ba_in;
          f_col  = addr_in[7:0];
        end
        if (!d.bon && d.bap) begin
          if (d.bwr) begin
            defer_v[ba_in] = 1'b1; // RL12
          end else begin
            close_v[ba_in] = 1'b1; // RL12
          end
        end
      end
      default: begin
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      if (close_v[i]) begin
        d.act[i] = 1'b0;
      end
      if (defer_v[i]) begin
        d.pend[i] = 1'b1;
        d.twr[i]  = sdp_pkg::TWR_CYC; // RL3 RL6 RL14
      end
    end
    if (fetch) begin
      d.pv[0] = 1'b1;
      d.pd[0] = mem[{f_bank, f_col}];
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q    <= '0;
      q.cl <= sdp_pkg::RST_CL;
      q.bl <= sdp_pkg::RST_BL;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Write path through the buffer
  // The array has one port; a read fetch stalls the drain, so a write
  // waits in the buffer during reads; it never holds more than one entry.
  assign drain_r = !fetch;

  sdp_fifo #(
    .W ($bits(sdp_pkg::sdp_wr_type)),
    .D (sdp_pkg::FIFO_D)
  ) sdp_fifo_inst (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_ready_out),
    .in_data_in    (push_w),
    .out_valid_out (drain_v),
    .out_ready_in  (drain_r),
    .out_data_out  (drain_w)
  );

  always_ff @(posedge mclk_in) begin
    if (drain_v && drain_r) begin
      if (drain_w.be[0]) begin
        mem[{drain_w.bank, drain_w.col}][7:0] <= drain_w.data[7:0];
      end
      if (drain_w.be[1]) begin
        mem[{drain_w.bank, drain_w.col}][15:8] <= drain_w.data[15:8];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign oidx            = (q.cl == 2'h3) ? 2'h2 : 2'h1;
  assign dq_out          = q.pd[oidx]; // RL2
  assign dq_oe_out       = q.pv[oidx];
  assign bank_open_out   = q.act;
  assign pre_pending_out = q.pend;

endmodule : sdp_core

// *** tb/sdp_core_checker.sv ***
// Port-level timing checks for the DRAM command core.
`timescale 1ns/1ps
module sdp_core_checker (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        cs_n_in,
  input wire logic        ras_n_in,
  input wire logic        cas_n_in,
  input wire logic        we_n_in,
  input wire logic [1:0]  ba_in,
  input wire logic [11:0] addr_in,
  input wire logic [1:0]  dqm_in,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe_out,
  input wire logic        buf_ready_out,
  input wire logic [3:0]  bank_open_out,
  input wire logic [3:0]  pre_pending_out
);
  localparam int TWR  = sdp_pkg::TWR_INT;
  localparam int TWR1 = TWR + 1;
  logic [3:0] c;
  logic       rd, wr, nop;
  logic       cl3_q;
  assign c   = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  assign rd  = c == 4'h5;
  assign wr  = c == 4'h4;
  assign nop = c == 4'h7;
  // Latency follows the last mode load; after reset it is two cycles.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cl3_q <= 1'b0;
    end else if (c == 4'h0) begin
      cl3_q <= (addr_in[sdp_pkg::MR_CL_LSB +: 2] == 2'h3);
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================================
  // Properties
  // These assume the burst length of four that the bench programs.
  sequence s_wap0;
    wr && addr_in[10] && ba_in == 2'h0 ##1 nop;
  endsequence
  property p_cs_nop;
    cs_n_in |=> (bank_open_out & ~$past(bank_open_out)) == 4'h0;
  endproperty
  property p_rd_cut;
    s_wap0 ##1 rd && ba_in != 2'h0 |=> pre_pending_out[0];
  endproperty
  property p_wr_cut;
    s_wap0 ##1 wr && ba_in != 2'h0 |=> pre_pending_out[0];
  endproperty
  property p_rd_close;
    s_wap0 ##1 rd && ba_in != 2'h0 |-> ##TWR1 !bank_open_out[0];
  endproperty
  property p_pend_close;
    $rose(pre_pending_out[0]) |-> bank_open_out[0] ##TWR !bank_open_out[0];
  endproperty
  property p_pend_one;
    $rose(pre_pending_out[1]) |-> ##TWR !pre_pending_out[1];
  endproperty
  property p_rd_cl;
    !cl3_q && rd ##1 !wr |-> ##1 dq_oe_out;
  endproperty
  property p_rd_cl3;
    cl3_q && rd ##1 !wr ##1 !wr |-> ##1 dq_oe_out;
  endproperty
  property p_ap_done;
    wr && addr_in[10] && ba_in == 2'h1 ##1 nop [*3] |=> pre_pending_out[1];
  endproperty
  a_cs_nop: assert property (p_cs_nop)
    else $error("bank opened on a deselected cycle");
  a_rd_cut: assert property (p_rd_cut)
    else $error("read did not cut the write burst");
  a_wr_cut: assert property (p_wr_cut)
    else $error("write did not cut the write burst");
  a_rd_close: assert property (p_rd_close)
    else $error("cut bank not closed after recovery");
  a_pend_close: assert property (p_pend_close)
    else $error("deferred close at wrong time");
  a_pend_one: assert property (p_pend_one)
    else $error("pending flag wrong length");
  a_rd_cl: assert property (p_rd_cl)
    else $error("read data not on time");
  a_rd_cl3: assert property (p_rd_cl3)
    else $error("read data not on time at latency three");
  a_ap_done: assert property (p_ap_done)
    else $error("auto close missing after burst");
  c_rd_cut: cover property (p_rd_cut);
  c_wr_cut: cover property (p_wr_cut);
  c_cs_off: cover property (cs_n_in && !ras_n_in);
  c_rd_cl3: cover property (p_rd_cl3);
endmodule : sdp_core_checker

bind sdp_core sdp_core_checker sdp_core_checker_inst (.*);

// *** tb/sdp_ctl_model.sv ***
// Controller-side model: passes commands on and flags its own slips.
`timescale 1ns/1ps
module sdp_ctl_model #(
  parameter int T_RAS = 3
) (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic [3:0] req_cmd_in,
  input  wire logic [1:0] ba_in,
  input  wire logic [3:0] bank_open_in,
  input  wire logic [3:0] pre_pending_in,
  output logic [3:0]      cmd_out,
  output logic            viol_out
);
  logic [3:0] ras_q;
  logic       act, pre;
  assign cmd_out = req_cmd_in;
  assign act     = req_cmd_in == 4'h3;
  assign pre     = req_cmd_in == 4'h2;
  // One shared row-active counter is stricter than per bank, never looser.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ras_q    <= 4'h0;
      viol_out <= 1'b0;
    end else begin
      ras_q <= act ? 4'(T_RAS) : ((ras_q != 4'h0) ? ras_q - 4'h1 : ras_q);
      if (act && (bank_open_in[ba_in] || pre_pending_in[ba_in])) begin
        viol_out <= 1'b1;
      end
      if (pre && ras_q > 4'h1) begin
        viol_out <= 1'b1;
      end
    end
  end
endmodule : sdp_ctl_model

// *** tb/sdp_core_tb_top.sv ***
// Self-checking bench for the DRAM command core.
`timescale 1ns/1ps
module sdp_core_tb_top;
  logic            mclk_in, nrst_in, dq_oe, buf_ready, viol;
  logic [3:0]      req_cmd, cmd, bank_open, pend, pend_q;
  logic [1:0]      ba;
  logic [11:0]     addr;
  logic [15:0]     dq, dq_out;
  int              num_errors, samples_checked;
  int              cl_now = 2;

  sdp_ctl_model sdp_ctl_model_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .req_cmd_in(req_cmd), .ba_in(ba), .bank_open_in(bank_open),
    .pre_pending_in(pend), .cmd_out(cmd), .viol_out(viol));
  sdp_core sdp_core_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .cs_n_in(cmd[3]), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]),
    .we_n_in(cmd[0]), .ba_in(ba), .addr_in(addr), .dqm_in(2'h0),
    .dq_in(dq), .dq_out(dq_out), .dq_oe_out(dq_oe),
    .buf_ready_out(buf_ready), .bank_open_out(bank_open),
    .pre_pending_out(pend));

  // ==========================================================
  // Shared tasks
  task automatic end_of_test;
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    req_cmd <= c;
    ba      <= b;
    addr    <= a;
    dq      <= d;
  endtask : issue
  task automatic idle(input int n);
    repeat (n) issue(4'h7, 2'h0, 12'h000, 16'h5A5A);
  endtask : idle
  task automatic wr4(input logic [1:0] b, input logic [7:0] col,
                     input logic [15:0] base, input logic ap);
    issue(4'h4, b, {1'b0, ap, 2'h0, col}, base);
    for (int k = 1; k < 4; k++) issue(4'h7, b, 12'h000, base + 16'(k));
  endtask : wr4
  // Column bits 8, 9 and 11 are driven high on every read.
  task automatic rd(input logic [1:0] b, input logic [7:0] col,
                    input logic [3:0][15:0] e);
    issue(4'h5, b, {4'hB, col}, 16'hEEEE);
    issue(4'h7, 2'h0, 12'h000, 16'h1111);
    #1 pend_q = pend;
    repeat (cl_now - 2) @(posedge mclk_in);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_in);
      #1 chk("read valid", dq_oe, 16'h1);
      chk("read data", dq_out, e[k]);
    end
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic sc_rd_int;
    wr4(2'h0, 8'h00, 16'h1000, 1'b0);
    wr4(2'h1, 8'h00, 16'h2000, 1'b0);
    idle(20);
    issue(4'h4, 2'h0, 12'h400, 16'hA000);
    issue(4'h7, 2'h0, 12'h000, 16'hA001);
    rd(2'h1, 8'h00, {16'h2003, 16'h2002, 16'h2001, 16'h2000});
    chk("pending bank0", pend_q[0], 16'h1);
    chk("bank0 open", bank_open[0], 16'h0);
    idle(20);
    issue(4'h3, 2'h0, 12'h000, 16'h0000);
    rd(2'h0, 8'h00, {16'h1003, 16'h1002, 16'hA001, 16'hA000});
  endtask : sc_rd_int
  task automatic sc_wr_int;
    wr4(2'h0, 8'h08, 16'h3000, 1'b0);
    issue(4'h4, 2'h0, 12'h408, 16'hB000);
    issue(4'h7, 2'h0, 12'h000, 16'hB001);
    wr4(2'h1, 8'h10, 16'hC000, 1'b1);
    chk("bank1 open", bank_open[1], 16'h1);
    chk("buffer ready", buf_ready, 16'h1);
    idle(20);
    chk("bank1 auto closed", bank_open[1], 16'h0);
    chk("bank0 closed", bank_open[0], 16'h0);
    issue(4'h3, 2'h0, 12'h000, 16'h0000);
    issue(4'h3, 2'h1, 12'h000, 16'h0000);
    rd(2'h0, 8'h08, {16'h3003, 16'h3002, 16'hB001, 16'hB000});
    rd(2'h1, 8'h10, {16'hC003, 16'hC002, 16'hC001, 16'hC000});
  endtask : sc_wr_int
  task automatic sc_cs_high;
    issue(4'hA, 2'h0, 12'h400, 16'h0000);
    issue(4'hB, 2'h2, 12'h000, 16'h0000);
    idle(2);
    chk("bank0 kept", bank_open[0], 16'h1);
    chk("bank2 idle", bank_open[2], 16'h0);
    issue(4'h2, 2'h0, 12'h000, 16'h0000);
    idle(3);
    chk("bank0 shut", bank_open[0], 16'h0);
  endtask : sc_cs_high
  // Latency three moves the first word one cycle later.
  task automatic sc_cl3;
    issue(4'h0, 2'h0, 12'h032, 16'h0000);
    cl_now = 3;
    rd(2'h1, 8'h10, {16'hC003, 16'hC002, 16'hC001, 16'hC000});
  endtask : sc_cl3

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (3000) @(posedge mclk_in);
    num_errors++;
    end_of_test();
  end
  initial begin
    {nrst_in, req_cmd, ba, addr, dq} = {1'b0, 4'hF, 2'h0, 12'h000, 16'h0};
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    issue(4'h0, 2'h0, 12'h022, 16'h0000);
    issue(4'h1, 2'h0, 12'h000, 16'h0000);
    issue(4'h3, 2'h0, 12'h000, 16'h0000);
    issue(4'h3, 2'h1, 12'h000, 16'h0000);
    sc_rd_int();
    sc_wr_int();
    sc_cs_high();
    sc_cl3();
    chk("controller timing", viol, 16'h0);
    end_of_test();
  end
endmodule : sdp_core_tb_top
